// ==== inc/ara_pkg.sv ====
// Shared constants and types for the accumulator RAM addressing block.
// Assumes a 32-bit APB host and a DDR controller core with a request
// and data-request handshake on the same 100 MHz clock.
package ara_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_MISC      = 10'h002;
  localparam logic [9:0] IDX_CELL_BASE = 10'h010;
  localparam logic [9:0] IDX_START_BLK = 10'h020;
  localparam logic [9:0] IDX_BLK_CNT   = 10'h021;
  localparam logic [9:0] IDX_INT_STAT  = 10'h0c0;
  localparam logic [9:0] IDX_INT_EN    = 10'h0c1;
  localparam logic [9:0] IDX_INT_CLR   = 10'h0c2;
  localparam int         NUM_CELLS     = 16;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MISC_RAM_SIZE   = 0;
  localparam int MISC_BANK_SPLIT = 1;
  localparam int CELL_RECIRC_EN  = 0;
  localparam int CELL_RANGE_ERR  = 1;
  localparam int INT_REJECT      = 0;
  localparam int INT_DONE        = 1;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [1:0]  MISC_RST      = 2'h0;
  localparam logic [7:0]  START_BLK_RST = 8'h00;
  localparam logic [7:0]  BLK_CNT_RST   = 8'h00;
  localparam logic [10:0] BIN_MAX_BASE  = 11'h3e7;
  localparam logic [10:0] BIN_MAX_WIDE  = 11'h7cf;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  cell_identifier;
    logic [11:0] phase_bin;
    logic [7:0]  recirc_block_number;
  } ara_hdr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_REQ  = 2'b11,
    ST_SEND = 2'b10
  } ara_state_t;

endpackage : ara_pkg

// ==== logic/ara_frame_mem.sv ====
// Single lag frame store between the correlator stream and DDR bursts.
// Assumes one write and one read port on one clock; read data lag by one.
`timescale 1ns/1ns
module ara_frame_mem #(
  parameter int DW    = 32,
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [DW-1:0] mem [DEPTH];

  // No reset on the array so it maps onto block RAM
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : ara_frame_mem

// ==== logic/ara_top.sv ====
// Accumulator RAM addressing: maps lag frames to DDR bins and bursts
// them to a DDR controller core; APB registers for configuration.
// Assumes header and word streams from logic on pclk, and a controller
// core that handles all DDR sequencing itself.
`timescale 1ns/1ns
module ara_top #(
  parameter int FRAME_WORDS = 128,
  parameter int ADDR_W      = 24,
  parameter int SIZE_W      = 8
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [11:0]        paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic      [31:0]        prdata,
  output logic                    pslverr,
  output logic                    irq,
  input  wire logic               hdr_valid,
  input  wire ara_pkg::ara_hdr_t  hdr,
  output logic                    hdr_ready,
  input  wire logic               word_valid,
  input  wire logic [31:0]        word_data,
  output logic                    word_ready,
  input  wire logic               local_init_done,
  output logic      [ADDR_W-1:0]  local_addr,
  output logic      [SIZE_W-1:0]  local_size,
  output logic                    local_write_req,
  input  wire logic               local_ready,
  input  wire logic               local_wdata_req,
  output logic      [31:0]        local_wdata
);

  localparam int CW = $clog2(FRAME_WORDS);
  localparam logic [CW-1:0] LAST_WORD = CW'(FRAME_WORDS - 1);
  localparam int NC = ara_pkg::NUM_CELLS;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [1:0]    misc_status_config;
  logic [7:0]    start_block_config;
  logic [7:0]    block_count_config;
  logic [NC-1:0] recirc_en;
  logic [NC-1:0] ram_range_error_flag;
  logic [1:0]    int_stat;
  logic [1:0]    int_en;
  logic [1:0]    next_misc;
  logic [7:0]    next_start;
  logic [7:0]    next_count;
  logic [NC-1:0] next_recirc_en;
  logic [NC-1:0] next_range_err;
  logic [1:0]    next_int_stat;
  logic [1:0]    next_int_en;
  logic [31:0]   next_prdata;
  logic          next_pslverr;

  logic          ev_reject;
  logic          ev_done;
  logic [3:0]    ev_cell;

  logic [9:0]    idx;
  logic          setup;
  logic          wr;
  logic          is_cell;
  logic [3:0]    cell_sel;
  logic          mapped;

  assign idx      = paddr[11:2];
  assign setup    = psel && !penable;
  assign wr       = psel && penable && pwrite;
  assign is_cell  = idx[9:4] == ara_pkg::IDX_CELL_BASE[9:4];
  assign cell_sel = idx[3:0];
  assign pready   = penable;
  assign irq      = |(int_stat & int_en);

  always_comb begin
    mapped = is_cell ||
             idx == ara_pkg::IDX_MISC ||
             idx == ara_pkg::IDX_START_BLK ||
             idx == ara_pkg::IDX_BLK_CNT ||
             idx == ara_pkg::IDX_INT_STAT ||
             idx == ara_pkg::IDX_INT_EN ||
             idx == ara_pkg::IDX_INT_CLR;
  end

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  // Read data and error are captured in the setup cycle so both come
  // from flops; the slave always answers in one access cycle.
  always_comb begin
    next_misc      = misc_status_config;
    next_start     = start_block_config;
    next_count     = block_count_config;
    next_recirc_en = recirc_en;
    next_range_err = ram_range_error_flag;
    next_int_stat  = int_stat;
    next_int_en    = int_en;
    next_prdata    = prdata;
    next_pslverr   = pslverr;
    if (setup) begin
      next_prdata  = '0;
      next_pslverr = !mapped;
      if (is_cell) begin
        next_prdata[ara_pkg::CELL_RECIRC_EN] = recirc_en[cell_sel];
        next_prdata[ara_pkg::CELL_RANGE_ERR] =
          ram_range_error_flag[cell_sel];
      end else if (idx == ara_pkg::IDX_MISC) begin
        next_prdata[1:0] = misc_status_config;
      end else if (idx == ara_pkg::IDX_START_BLK) begin
        next_prdata[7:0] = start_block_config;
      end else if (idx == ara_pkg::IDX_BLK_CNT) begin
        next_prdata[7:0] = block_count_config;
      end else if (idx == ara_pkg::IDX_INT_STAT) begin
        next_prdata[1:0] = int_stat;
      end else if (idx == ara_pkg::IDX_INT_EN) begin
        next_prdata[1:0] = int_en;
      end
    end
    if (wr) begin
      if (is_cell) begin
        next_recirc_en[cell_sel] = pwdata[ara_pkg::CELL_RECIRC_EN];
        if (pwdata[ara_pkg::CELL_RANGE_ERR]) begin
          next_range_err[cell_sel] = 1'b0;
        end
      end else if (idx == ara_pkg::IDX_MISC) begin
        next_misc = pwdata[1:0];
      end else if (idx == ara_pkg::IDX_START_BLK) begin
        next_start = pwdata[7:0];
      end else if (idx == ara_pkg::IDX_BLK_CNT) begin
        next_count = pwdata[7:0];
      end else if (idx == ara_pkg::IDX_INT_EN) begin
        next_int_en = pwdata[1:0];
      end else if (idx == ara_pkg::IDX_INT_CLR) begin
        next_int_stat = int_stat & ~pwdata[1:0];
      end
    end
    // Hardware set wins over a clear in the same cycle
    if (ev_reject) begin
      next_range_err[ev_cell] = 1'b1;
      next_int_stat[ara_pkg::INT_REJECT] = 1'b1;
    end
    if (ev_done) begin
      next_int_stat[ara_pkg::INT_DONE] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misc_status_config   <= ara_pkg::MISC_RST;
      start_block_config   <= ara_pkg::START_BLK_RST;
      block_count_config   <= ara_pkg::BLK_CNT_RST;
      recirc_en            <= '0;
      ram_range_error_flag <= '0;
      int_stat             <= '0;
      int_en               <= '0;
      prdata               <= '0;
      pslverr              <= 1'b0;
    end else begin
      misc_status_config   <= next_misc;
      start_block_config   <= next_start;
      block_count_config   <= next_count;
      recirc_en            <= next_recirc_en;
      ram_range_error_flag <= next_range_err;
      int_stat             <= next_int_stat;
      int_en               <= next_int_en;
      prdata               <= next_prdata;
      pslverr              <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Bin address calculation
  // ----------------------------------------------------------------
  logic          wide;
  logic          dbl;
  logic          bank;
  logic [10:0]   pb_low;
  logic [10:0]   bin_max;
  logic [7:0]    nblocks;
  logic [8:0]    nb_plus;
  logic [19:0]   prod;
  logic [20:0]   bin;
  logic          bad;
  logic [ADDR_W-1:0] calc_addr;

  always_comb begin
    dbl  = misc_status_config[ara_pkg::MISC_RAM_SIZE];
    wide = dbl && !misc_status_config[ara_pkg::MISC_BANK_SPLIT];
    // Bank is the top phase bit of the active map size
    bank = wide ? hdr.phase_bin[11] : hdr.phase_bin[10];
    pb_low  = wide ? hdr.phase_bin[10:0]
                   : {1'b0, hdr.phase_bin[9:0]};
    bin_max = wide ? ara_pkg::BIN_MAX_WIDE
                   : ara_pkg::BIN_MAX_BASE;
    nblocks = recirc_en[hdr.cell_identifier] ? block_count_config
                                             : 8'h00;
    nb_plus = {1'b0, nblocks} + 9'h001;
    prod    = pb_low * nb_plus;
    bin     = {1'b0, prod}
            + {13'h0000, hdr.recirc_block_number}
            - {13'h0000, start_block_config};
    // Header bins above the data range are never written
    bad = pb_low > bin_max || bin[20] ||
          bin[19:0] > {9'h000, bin_max};
    calc_addr = dbl ? {bank, bin[10:0], 12'h000}
                    : {1'b0, bank, bin[10:0], 11'h000};
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  ara_pkg::ara_state_t state;
  ara_pkg::ara_state_t next_state;
  logic [CW-1:0]     wcnt;
  logic [CW-1:0]     rcnt;
  logic              drop;
  logic [3:0]        cell_q;
  logic [CW-1:0]     next_wcnt;
  logic [CW-1:0]     next_rcnt;
  logic              next_drop;
  logic [3:0]        next_cell;
  logic [ADDR_W-1:0] next_addr;
  logic [SIZE_W-1:0] next_size;
  logic              mem_wr;
  logic              mem_rd;

  assign hdr_ready       = state == ara_pkg::ST_IDLE;
  assign word_ready      = state == ara_pkg::ST_FILL;
  assign local_write_req = state == ara_pkg::ST_REQ;
  assign mem_wr          = word_ready && word_valid && !drop;
  // Only a data request pulls a word from the frame store
  assign mem_rd = state == ara_pkg::ST_SEND && local_wdata_req;
  assign ev_cell = cell_q;

  always_comb begin
    next_state = state;
    next_wcnt  = wcnt;
    next_rcnt  = rcnt;
    next_drop  = drop;
    next_cell  = cell_q;
    next_addr  = local_addr;
    next_size  = local_size;
    ev_reject  = 1'b0;
    ev_done    = 1'b0;
    unique case (state)
      ara_pkg::ST_IDLE: begin
        if (hdr_valid) begin
          next_cell  = hdr.cell_identifier;
          next_drop  = bad;
          ev_reject  = bad;
          // Address and size settle before the request rises
          next_addr  = calc_addr;
          next_size  = SIZE_W'(FRAME_WORDS);
          next_wcnt  = '0;
          next_state = ara_pkg::ST_FILL;
        end
      end
      ara_pkg::ST_FILL: begin
        if (word_valid) begin
          next_wcnt = wcnt + 1'b1;
          if (wcnt == LAST_WORD) begin
            // Rejected frame is consumed but never reaches memory
            next_state = drop ? ara_pkg::ST_IDLE
                              : ara_pkg::ST_REQ;
          end
        end
      end
      ara_pkg::ST_REQ: begin
        // Core owns DDR init and refresh; wait for it to be ready
        if (local_init_done && local_ready) begin
          next_rcnt  = '0;
          next_state = ara_pkg::ST_SEND;
        end
      end
      ara_pkg::ST_SEND: begin
        if (local_wdata_req) begin
          next_rcnt = rcnt + 1'b1;
          if (rcnt == LAST_WORD) begin
            ev_done    = 1'b1;
            next_state = ara_pkg::ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ara_pkg::ST_IDLE;
      wcnt       <= '0;
      rcnt       <= '0;
      drop       <= 1'b0;
      cell_q     <= 4'h0;
      local_addr <= '0;
      local_size <= '0;
    end else begin
      state      <= next_state;
      wcnt       <= next_wcnt;
      rcnt       <= next_rcnt;
      drop       <= next_drop;
      cell_q     <= next_cell;
      local_addr <= next_addr;
      local_size <= next_size;
    end
  end

  // ----------------------------------------------------------------
  // Frame store
  // ----------------------------------------------------------------
  // Whole frame is held so a burst never starves the controller
  ara_frame_mem #(
    .DW    (32),
    .DEPTH (FRAME_WORDS),
    .AW    (CW)
  ) u_mem (
    .clk     (pclk),
    .rst_n   (presetn),
    .wr_en   (mem_wr),
    .wr_addr (wcnt),
    .wr_data (word_data),
    .rd_en   (mem_rd),
    .rd_addr (rcnt),
    .rd_data (local_wdata)
  );

endmodule : ara_top

// ==== bench/ara_chk.sv ====
// Checker for the frame and burst ports of ara_top.
// Assumes it is bound to ara_top and sees its ports only.
`timescale 1ns/1ns
module ara_chk #(
  parameter int FRAME_WORDS = 128,
  parameter int ADDR_W      = 24,
  parameter int SIZE_W      = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              hdr_valid,
  input wire logic              hdr_ready,
  input wire logic              word_valid,
  input wire logic              word_ready,
  input wire logic              local_init_done,
  input wire logic [ADDR_W-1:0] local_addr,
  input wire logic [SIZE_W-1:0] local_size,
  input wire logic              local_write_req,
  input wire logic              local_ready
);
  // ----------------------------------------------------------------
  // Word counter, since frames carry no last flag
  // ----------------------------------------------------------------
  int wcnt;
  int next_wcnt;
  always_comb begin
    next_wcnt = wcnt;
    if (hdr_valid && hdr_ready) next_wcnt = 0;
    else if (word_valid && word_ready) next_wcnt = wcnt + 1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wcnt <= 0;
    else wcnt <= next_wcnt;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_hdr_to_fill: assert property (
    hdr_valid && hdr_ready |=> word_ready && !hdr_ready)
    else $error("header did not open the word phase");
  chk_fill_no_req: assert property (
    word_ready |-> !local_write_req && !hdr_ready)
    else $error("request raised while words still arrive");
  chk_last_word: assert property (
    word_valid && word_ready && wcnt == FRAME_WORDS - 1
    |=> !word_ready && (local_write_req || hdr_ready))
    else $error("frame end not followed by request or idle");
  chk_req_holds: assert property (
    local_write_req && !(local_ready && local_init_done) |=> local_write_req)
    else $error("write request dropped before acceptance");
  chk_req_leaves: assert property (
    local_write_req && local_ready && local_init_done
    |=> !local_write_req [*2] ##0 !hdr_ready)
    else $error("request kept or idle entered before data");
  chk_addr_stable: assert property (
    local_write_req && $past(local_write_req)
    |-> $stable(local_addr) && $stable(local_size))
    else $error("address or size moved under request");
  chk_size_frame: assert property (
    local_write_req |-> local_size == SIZE_W'(FRAME_WORDS))
    else $error("burst size differs from frame length");
  chk_low_zero: assert property (
    local_write_req |-> local_addr[10:0] == 11'h000)
    else $error("bin address not aligned to bin slot");
endmodule : ara_chk

// ==== bench/ara_ctrl_model.sv ====
// Model of the DDR controller core's user port.
// Assumes one clock shared with the design; slow adds waits.
`timescale 1ns/1ns
module ara_ctrl_model #(
  parameter int FW = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  input  wire logic [23:0] local_addr,
  input  wire logic        local_write_req,
  output logic             local_init_done,
  output logic             local_ready,
  output logic             local_wdata_req,
  input  wire logic [31:0] local_wdata,
  output logic      [23:0] last_addr,
  output int               bursts,
  output logic      [31:0] got [FW]
);
  int   init_cnt;
  int   wait_cnt;
  int   left;
  int   idx;
  logic pend;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {local_init_done, local_ready, local_wdata_req, pend} <= '0;
      {init_cnt, wait_cnt, left, idx, bursts} <= '0;
    end else begin
      local_ready <= 1'b0;
      pend        <= local_wdata_req;
      // Init sequence hidden from the user side
      if (init_cnt < 8) init_cnt <= init_cnt + 1;
      else local_init_done <= 1'b1;
      // One word per request cycle, gaps when slow
      left            <= left - int'(local_wdata_req);
      local_wdata_req <= (left - int'(local_wdata_req)) > 0
                         && !(slow && local_wdata_req);
      if (local_write_req && local_ready && local_init_done) begin
        left      <= FW;
        idx       <= 0;
        last_addr <= local_addr;
      end else if (local_write_req && local_init_done) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt >= (slow ? 3 : 0)) begin
          local_ready <= 1'b1;
          wait_cnt    <= 0;
        end
      end
      // Data lags its request by one cycle
      if (pend) begin
        got[idx] <= local_wdata;
        idx      <= idx + 1;
        if (idx == FW - 1) bursts <= bursts + 1;
      end
    end
  end
endmodule : ara_ctrl_model

// ==== bench/tb_accumulator_ram_addressing.sv ====
// Testbench: APB set-up, frames in, bursts checked at a core model.
// Assumes ara_pkg and a four-word frame to keep runs short.
`timescale 1ns/1ns
module tb_accumulator_ram_addressing;
  localparam int FW = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic hdr_valid, hdr_ready, word_valid, word_ready, slow;
  logic local_init_done, local_write_req, local_ready, local_wdata_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, word_data, local_wdata, rd;
  logic [23:0] local_addr, last_addr;
  logic [7:0]  local_size;
  logic [31:0] got [FW];
  ara_pkg::ara_hdr_t hdr;
  int num_errors, checked, bursts;

  ara_top #(.FRAME_WORDS(FW), .ADDR_W(24), .SIZE_W(8)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .hdr_valid(hdr_valid), .hdr(hdr), .hdr_ready(hdr_ready),
    .word_valid(word_valid), .word_data(word_data),
    .word_ready(word_ready), .local_init_done(local_init_done),
    .local_addr(local_addr), .local_size(local_size),
    .local_write_req(local_write_req), .local_ready(local_ready),
    .local_wdata_req(local_wdata_req), .local_wdata(local_wdata));
  ara_ctrl_model #(.FW(FW)) core_u (
    .pclk(pclk), .presetn(presetn), .slow(slow), .local_addr(local_addr),
    .local_write_req(local_write_req), .local_init_done(local_init_done),
    .local_ready(local_ready), .local_wdata_req(local_wdata_req),
    .local_wdata(local_wdata), .last_addr(last_addr), .bursts(bursts),
    .got(got));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic [9:0] i, input logic w,
                     input logic [31:0] v);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, i, 2'b00, v};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rdchk(input logic [9:0] i, input logic [31:0] e);
    apb(i, 1'b0, 32'h0);
    chk(rd, e);
  endtask : rdchk
  task automatic irqchk(input logic e);
    @(posedge pclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : irqchk
  function automatic logic [23:0] ea(input logic s, input logic b,
                                     input logic [10:0] n);
    ea = s ? {b, n, 12'h000} : {1'b0, b, n, 11'h000};
  endfunction : ea
  task automatic frame(input logic [3:0] c, input logic [11:0] p,
                       input logic [7:0] r, input logic ok,
                       input logic [23:0] a);
    int n0;
    n0 = bursts;
    @(posedge pclk);
    hdr_valid <= 1'b1;
    hdr       <= ara_pkg::ara_hdr_t'({c, p, r});
    do @(posedge pclk); while (hdr_ready !== 1'b1);
    hdr_valid <= 1'b0;
    for (int k = 0; k < FW; k++) begin
      word_valid <= 1'b1;
      word_data  <= {p, 20'(k)};
      do @(posedge pclk); while (word_ready !== 1'b1);
    end
    word_valid <= 1'b0;
    do @(posedge pclk); while (hdr_ready !== 1'b1);
    repeat (3) @(posedge pclk);
    chk(32'(bursts - n0), {31'h0, ok});
    if (ok) chk({8'h0, last_addr}, {8'h0, a});
    for (int k = 0; k < FW; k++) if (ok) chk(got[k], {p, 20'(k)});
  endtask : frame
  task automatic wrap_up;
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, hdr_valid, word_valid, slow} = '0;
    {paddr, pwdata, hdr, word_data, num_errors, checked} = '0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(ara_pkg::IDX_MISC, 32'h0);
    rdchk(ara_pkg::IDX_START_BLK, 32'h0);
    rdchk(ara_pkg::IDX_BLK_CNT, 32'h0);
    rdchk(10'h3ff, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test registers done");
    apb(ara_pkg::IDX_BLK_CNT, 1'b1, 32'h3);
    rdchk(ara_pkg::IDX_BLK_CNT, 32'h3);
    apb(ara_pkg::IDX_START_BLK, 1'b1, 32'h1);
    apb(ara_pkg::IDX_CELL_BASE + 10'h2, 1'b1, 32'h1);
    slow <= 1'b1;
    frame(4'h2, 12'h405, 8'h02, 1'b1, ea(1'b0, 1'b1, 11'd21));
    slow <= 1'b0;
    frame(4'h3, 12'h007, 8'h01, 1'b1, ea(1'b0, 1'b0, 11'd7));
    frame(4'h3, 12'h3e7, 8'h01, 1'b1, ea(1'b0, 1'b0, 11'd999));
    // Three clean bursts leave only the done bit standing
    rdchk(ara_pkg::IDX_INT_STAT, 32'h2);
    $display("test bins done");
    apb(ara_pkg::IDX_INT_CLR, 1'b1, 32'h3);
    frame(4'h3, 12'h3e8, 8'h01, 1'b0, 24'h0);
    rdchk(ara_pkg::IDX_CELL_BASE + 10'h3, 32'h2);
    rdchk(ara_pkg::IDX_INT_STAT, 32'h1);
    apb(ara_pkg::IDX_INT_EN, 1'b1, 32'h1);
    irqchk(1'b1);
    apb(ara_pkg::IDX_INT_EN, 1'b1, 32'h0);
    irqchk(1'b0);
    apb(ara_pkg::IDX_INT_EN, 1'b1, 32'h1);
    apb(ara_pkg::IDX_INT_CLR, 1'b1, 32'h1);
    irqchk(1'b0);
    rdchk(ara_pkg::IDX_INT_CLR, 32'h0);
    apb(ara_pkg::IDX_CELL_BASE + 10'h3, 1'b1, 32'h2);
    rdchk(ara_pkg::IDX_CELL_BASE + 10'h3, 32'h0);
    $display("test reject done");
    apb(ara_pkg::IDX_MISC, 1'b1, 32'h1);
    frame(4'h3, 12'hddc, 8'h01, 1'b1, ea(1'b1, 1'b1, 11'h5dc));
    frame(4'h2, 12'h000, 8'h81, 1'b1, ea(1'b1, 1'b0, 11'd128));
    frame(4'h3, 12'h7d0, 8'h01, 1'b0, 24'h0);
    // Phase in range but bin lands past the data area
    frame(4'h2, 12'h1f4, 8'h01, 1'b0, 24'h0);
    rdchk(ara_pkg::IDX_CELL_BASE + 10'h2, 32'h3);
    // Double size split in two banks of the base limit
    apb(ara_pkg::IDX_MISC, 1'b1, 32'h3);
    frame(4'h3, 12'h405, 8'h01, 1'b1, ea(1'b1, 1'b1, 11'd5));
    $display("test double map done");
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    wrap_up();
  end
endmodule : tb_accumulator_ram_addressing

bind ara_top ara_chk #(.FRAME_WORDS(FRAME_WORDS), .ADDR_W(ADDR_W),
  .SIZE_W(SIZE_W)) chk_u (.pclk(pclk), .presetn(presetn),
  .hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .word_valid(word_valid),
  .word_ready(word_ready), .local_init_done(local_init_done),
  .local_addr(local_addr), .local_size(local_size),
  .local_write_req(local_write_req), .local_ready(local_ready));
